//--- verilog/pin_mux_pkg.sv
// Constants and carriers for the shared port pin mode control block.
// Assumes one system clock and a plain word-addressed register port.
// Contract
// - Mode bit 1 selects alternate function mode.
// - Data read: latch if direction 0, pin otherwise.
// - Data write updates only the output latch.
// - Alternate input equals mode bit AND pin.
package pin_mux_pkg;
    localparam int ADDR_W = 4;
    localparam int BUS_W  = 16;
    localparam int PORT_W = 16;
    localparam int ALT_N  = 4;

    localparam logic [ADDR_W-1:0] ADDR_PORT_DATA   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIR     = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PIN_MODE    = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_ALT_SEL     = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_ALT_SEL_EXT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL   = 4'h5;

    localparam logic [BUS_W-1:0] RST_PORT_DATA = 16'h0000;
    localparam logic [BUS_W-1:0] RST_PIN_DIR   = 16'hFFFF;
    localparam logic [BUS_W-1:0] RST_PIN_MODE  = 16'h0000;
    localparam logic [BUS_W-1:0] RST_ALT_SEL   = 16'h0000;
    localparam logic [BUS_W-1:0] RST_READ      = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BUS_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;
endpackage

//--- verilog/pin_sync.sv
// Two-stage synchroniser for a vector of pin levels.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second, to keep metastability contained.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- verilog/port_pin_mode_control.sv
// Mode control, function selection and port data for a group of shared pins.
// Assumes pins arrive asynchronously; peripheral drive signals share clk_sys.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module port_pin_mode_control #(
    parameter int WIDTH = pin_mux_pkg::PORT_W
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  resetn,
    input  wire pin_mux_pkg::bus_req_s                 bus_req,
    output logic [pin_mux_pkg::BUS_W-1:0]              rdata_q,
    input  wire logic [WIDTH-1:0]                      pin_i,
    output logic [WIDTH-1:0]                           pin_o_q,
    output logic [WIDTH-1:0]                           pin_oe_n_q,
    input  wire logic [pin_mux_pkg::ALT_N-1:0][WIDTH-1:0] alt_out,
    input  wire logic [pin_mux_pkg::ALT_N-1:0][WIDTH-1:0] alt_oe_n,
    output logic [WIDTH-1:0]                           alt_in_q,
    output logic [WIDTH-1:0]                           mode_q
);
    logic [WIDTH-1:0] data_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] sel_q;
    logic [WIDTH-1:0] sel_ext_q;
    logic [WIDTH-1:0] pin_s;
    logic [WIDTH-1:0] pin_o_d;
    logic [WIDTH-1:0] pin_oe_n_d;
    logic [pin_mux_pkg::BUS_W-1:0] rdata_d;

    // Narrow ports zero-extend onto the bus so upper bits read as zero.
    function automatic logic [pin_mux_pkg::BUS_W-1:0] widen(input logic [WIDTH-1:0] v);
        logic [pin_mux_pkg::BUS_W-1:0] r;
        r = '0;
        r[WIDTH-1:0] = v;
        return r;
    endfunction

    function automatic logic wr_hit(input pin_mux_pkg::bus_req_s q,
                                    input logic [pin_mux_pkg::ADDR_W-1:0] a);
        return q.wr && (q.addr == a);
    endfunction

    pin_sync #(
        .WIDTH    (WIDTH)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (pin_i),
        .sync_out (pin_s)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            data_q <= pin_mux_pkg::RST_PORT_DATA[WIDTH-1:0];
        end else if (wr_hit(bus_req, pin_mux_pkg::ADDR_PORT_DATA)) begin
            data_q <= bus_req.wdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dir_q <= pin_mux_pkg::RST_PIN_DIR[WIDTH-1:0];
        end else if (wr_hit(bus_req, pin_mux_pkg::ADDR_PIN_DIR)) begin
            dir_q <= bus_req.wdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_q <= pin_mux_pkg::RST_PIN_MODE[WIDTH-1:0];
        end else if (wr_hit(bus_req, pin_mux_pkg::ADDR_PIN_MODE)) begin
            mode_q <= bus_req.wdata[WIDTH-1:0];
        end
    end

    // Selects take effect at once, even with the mode bit set, so software
    // must order its writes; hardware does not hold back a late select.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_q     <= pin_mux_pkg::RST_ALT_SEL[WIDTH-1:0];
            sel_ext_q <= pin_mux_pkg::RST_ALT_SEL[WIDTH-1:0];
        end else begin
            if (wr_hit(bus_req, pin_mux_pkg::ADDR_ALT_SEL)) begin
                sel_q <= bus_req.wdata[WIDTH-1:0];
            end
            if (wr_hit(bus_req, pin_mux_pkg::ADDR_ALT_SEL_EXT)) begin
                sel_ext_q <= bus_req.wdata[WIDTH-1:0];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (mode_q[i]) begin
                // The latch is not looked at here at all.
                pin_o_d[i]    = alt_out[{sel_ext_q[i], sel_q[i]}][i];
                pin_oe_n_d[i] = alt_oe_n[{sel_ext_q[i], sel_q[i]}][i];
            end else begin
                pin_o_d[i]    = data_q[i];
                pin_oe_n_d[i] = dir_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_o_q    <= '0;
            pin_oe_n_q <= '1;
        end else begin
            pin_o_q    <= pin_o_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // Peripherals see low while a pin is in port mode, which is why they
    // must be enabled only after the mode bit is set.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            alt_in_q <= '0;
        end else begin
            alt_in_q <= mode_q & pin_s;
        end
    end

    always_comb begin
        case (bus_req.addr)
            pin_mux_pkg::ADDR_PORT_DATA:   rdata_d = widen((dir_q & pin_s) | (~dir_q & data_q));
            pin_mux_pkg::ADDR_PIN_DIR:     rdata_d = widen(dir_q);
            pin_mux_pkg::ADDR_PIN_MODE:    rdata_d = widen(mode_q);
            pin_mux_pkg::ADDR_ALT_SEL:     rdata_d = widen(sel_q);
            pin_mux_pkg::ADDR_ALT_SEL_EXT: rdata_d = widen(sel_ext_q);
            pin_mux_pkg::ADDR_PIN_LEVEL:   rdata_d = widen(pin_s);
            default:                       rdata_d = pin_mux_pkg::RST_READ;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= pin_mux_pkg::RST_READ;
        end else if (bus_req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= pin_mux_pkg::RST_READ;
        end
    end
endmodule

//--- tb/port_pin_mode_control_asserts.sv
// Checker for the shared pin block, bound to its top-level ports.
// Assumes one clock domain and the registered read port.
`timescale 1ns/100ps
module pin_mode_chk #(parameter int WIDTH = 16) (
    input wire logic                        clk_sys,
    input wire logic                        resetn,
    input wire pin_mux_pkg::bus_req_s       bus_req,
    input wire logic [15:0]                 rdata_q,
    input wire logic [WIDTH-1:0]            pin_i,
    input wire logic [WIDTH-1:0]            pin_o_q,
    input wire logic [WIDTH-1:0]            pin_oe_n_q,
    input wire logic [3:0][WIDTH-1:0]       alt_out,
    input wire logic [3:0][WIDTH-1:0]       alt_oe_n,
    input wire logic [WIDTH-1:0]            alt_in_q,
    input wire logic [WIDTH-1:0]            mode_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    localparam logic [3:0] AM = 4'h2;
    logic [WIDTH-1:0] s_oe, s_out;
    logic [WIDTH-1:0] oe_chk;
    logic [WIDTH-1:0] out_chk;
    // Bits where all codes agree can be checked without seeing the selects.
    assign s_oe  = ~((alt_oe_n[0] ^ alt_oe_n[1]) | (alt_oe_n[0] ^ alt_oe_n[2]));
    assign s_out = ~((alt_out[0] ^ alt_out[1]) | (alt_out[0] ^ alt_out[3]));
    assign oe_chk  = mode_q & s_oe & ~(alt_oe_n[0] ^ alt_oe_n[3]);
    assign out_chk = mode_q & s_out & ~(alt_out[0] ^ alt_out[2]);
    a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata_q == '0)
        else $error("read data outside its slot");
    a_mode_write: assert property (bus_req.wr && bus_req.addr == AM
        |=> mode_q == $past(bus_req.wdata[WIDTH-1:0])) else $error("mode write lost");
    a_mode_read: assert property (bus_req.rd && bus_req.addr == AM
        |=> rdata_q[WIDTH-1:0] == $past(mode_q)) else $error("mode read wrong");
    a_data_keeps_mode: assert property (bus_req.wr && bus_req.addr == 4'h0
        |=> $stable(mode_q)) else $error("data write touched mode");
    a_and_low: assert property ((alt_in_q & ~$past(mode_q)) == '0)
        else $error("peripheral input high in port mode");
    a_and_follow: assert property ((&mode_q && $stable(pin_i))[*4]
        |-> alt_in_q == pin_i) else $error("peripheral input not pin");
    a_alt_oe_pass: assert property (((pin_oe_n_q ^ $past(alt_oe_n[0]))
        & $past(oe_chk)) == '0)
        else $error("pin enable not from peripheral");
    a_alt_out_pass: assert property (((pin_o_q ^ $past(alt_out[0]))
        & $past(out_chk)) == '0)
        else $error("pin value not from peripheral");
    c_mode_read: cover property (bus_req.rd && bus_req.addr == AM);
    c_alt_in: cover property (&mode_q && alt_in_q != '0);
    c_mode_off: cover property ($fell(mode_q[0]));
endmodule
bind port_pin_mode_control pin_mode_chk #(.WIDTH(WIDTH)) chk_u (.*);

//--- tb/pin_far_side.sv
// Outside world of the pins: external driver and four peripheral drivers.
// Assumes the bench supplies the level the external device drives.
`timescale 1ns/100ps
module pin_far_side (
    input  wire logic [15:0]    pin_o_q,
    input  wire logic [15:0]    pin_oe_n_q,
    input  wire logic [15:0]    ext_lvl,
    output logic      [15:0]    pin_i,
    output logic [3:0][15:0]    alt_out,
    output logic [3:0][15:0]    alt_oe_n
);
    // Upper nibble agrees across codes so the checker can follow it.
    assign alt_out  = {16'hA0F0, 16'hA055, 16'hA033, 16'hA00F};
    assign alt_oe_n = {16'h0033, 16'h0F0F, 16'h00FF, 16'h0000};
    assign pin_i    = (pin_oe_n_q & ext_lvl) | (~pin_oe_n_q & pin_o_q);
endmodule

//--- tb/tb_port_pin_mode_control.sv
// Bench for the shared pin block with its outside-world model.
// Assumes read data stand only in the cycle after the strobe.
`timescale 1ns/100ps
module tb_port_pin_mode_control;
    logic clk_sys, resetn;
    pin_mux_pkg::bus_req_s req;
    logic [15:0] rdata_q, pin_i, pin_o_q, oe_n, alt_in_q, mode_q, ext_lvl, exp, oe_x;
    logic [3:0][15:0] alt_out, alt_oe_n;
    int bad_count = 0, total_checks = 0, cyc = 0;
    // Each pin group gets its own select code, so all four codes are used.
    localparam logic [15:0] SEL_V = 16'h00FF;
    localparam logic [15:0] EXT_V = 16'h0F0F;
    port_pin_mode_control dut_u (.clk_sys(clk_sys), .resetn(resetn), .bus_req(req),
        .rdata_q(rdata_q), .pin_i(pin_i), .pin_o_q(pin_o_q), .pin_oe_n_q(oe_n),
        .alt_out(alt_out), .alt_oe_n(alt_oe_n), .alt_in_q(alt_in_q), .mode_q(mode_q));
    pin_far_side far_u (.pin_o_q(pin_o_q), .pin_oe_n_q(oe_n), .ext_lvl(ext_lvl),
        .pin_i(pin_i), .alt_out(alt_out), .alt_oe_n(alt_oe_n));
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // The whole run needs about 50 cycles; the ceiling leaves wide margin.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        total_checks++;
        if (got !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] want);
        @(posedge clk_sys);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk(rdata_q, want);
    endtask
    task automatic t_reset();
        rd(4'h1, 16'hFFFF);
        rd(4'h2, 16'h0000);
        rd(4'h0, 16'h3C3C);
        rd(4'hA, 16'h0000);
        chk(oe_n, 16'hFFFF);
        $display("test reset done");
    endtask
    task automatic t_port();
        wr(4'h1, 16'hFF00);
        wr(4'h0, 16'hA5A5);
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_o_q & 16'h00FF, 16'h00A5);
        chk(oe_n, 16'hFF00);
        chk(alt_in_q, 16'h0000);
        rd(4'h0, 16'h3CA5);
        $display("test port done");
    endtask
    task automatic t_alt();
        // Selects go in before the mode bit so the pins never glitch.
        wr(4'h3, SEL_V);
        wr(4'h4, EXT_V);
        rd(4'h3, SEL_V);
        rd(4'h4, EXT_V);
        wr(4'h2, 16'hFFFF);
        for (int i = 0; i < 16; i++) begin
            exp[i] = alt_out[{EXT_V[i], SEL_V[i]}][i];
            oe_x[i] = alt_oe_n[{EXT_V[i], SEL_V[i]}][i];
        end
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_o_q, exp);
        chk(oe_n, oe_x);
        chk(alt_in_q, (oe_x & ext_lvl) | (~oe_x & exp));
        rd(4'h5, 16'hAC30);
        wr(4'h0, 16'h1234);
        repeat (2) @(posedge clk_sys);
        #1 chk(pin_o_q, exp);
        rd(4'h0, 16'hAC34);
        wr(4'h2, 16'h0000);
        repeat (2) @(posedge clk_sys);
        #1 chk(alt_in_q, 16'h0000);
        chk(pin_o_q & 16'h00FF, 16'h0034);
        $display("test alternate done");
    endtask
    initial begin
        req = '0;
        ext_lvl = 16'h3C3C;
        resetn = 0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1;
        t_reset();
        t_port();
        t_alt();
        end_sim();
    end
endmodule
